/* File: logic/rjh_jog_ctrl.sv */
`timescale 1ns/10ps
module rjh_jog_ctrl #(
    parameter int FILTER_CYCLES = rjh_pkg::FILTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Fieldbus side
    input wire logic link_ok_i,
    input wire rjh_pkg::rjh_jog_req_s remote_req_i,
    output rjh_pkg::rjh_jog_sts_s remote_sts_o,
    // Local I/O connector
    input wire rjh_pkg::rjh_jog_req_s local_req_i,
    output rjh_pkg::rjh_jog_sts_s local_sts_o,
    // Controller conditions
    input wire logic pendant_active_i,
    input wire logic tool_busy_i,
    input wire logic running_i,
    input wire logic error_i,
    input wire logic homed_i,
    input wire logic signed [31:0] position_i,
    // Motion core command
    output rjh_pkg::rjh_mot_cmd_s mot_cmd_o
);
    // Config registers
    logic [15:0] low_speed;
    logic [15:0] high_speed;
    logic [31:0] inch_step;
    logic signed [31:0] lim_min;
    logic signed [31:0] lim_max;

    // Combined raw and filtered jog inputs
    rjh_pkg::rjh_jog_req_s raw_req;
    rjh_pkg::rjh_jog_req_s filt_req;
    logic [3:0] axis_prev; // For rising edge of requests

    // Handshake state and captured conditions
    rjh_pkg::rjh_state_e state;
    rjh_pkg::rjh_state_e next_state;
    rjh_pkg::rjh_cls_e cls_cap;
    logic dir_cap;
    logic [3:0] axis_cap;
    logic permit_q;

    // Decoded helpers
    rjh_pkg::rjh_cls_e cls_now;
    logic cond_ok;
    logic axis_onehot;
    logic axis_rise;
    logic at_limit;
    logic start_ok;
    logic stop_req;

    // Remote bits count only while the link is up; local ORed in
    always_comb begin
        raw_req = local_req_i; // [R15]
        if (link_ok_i) begin
            raw_req = remote_req_i | local_req_i; // [R15]
        end
    end

    // Per-bit debounce: a level must hold FILTER_CYCLES to pass
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_filt
            logic [rjh_pkg::FILT_CNT_W-1:0] cnt; // Stable-time counter
            logic raw_bit;
            assign raw_bit = raw_req[gi];
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    cnt <= '0;
                    filt_req[gi] <= 1'b0;
                end else if (raw_bit == filt_req[gi]) begin
                    cnt <= '0; // Short pulse discarded [R5]
                end else if (cnt == rjh_pkg::FILT_CNT_W'(FILTER_CYCLES - 1))
                begin
                    cnt <= '0;
                    filt_req[gi] <= raw_bit; // [R5]
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    endgenerate

    // Class priority: inching over low over high
    always_comb begin
        if (filt_req.inch) begin
            cls_now = rjh_pkg::RJH_CLS_INCH; // [R9]
        end else if (filt_req.low) begin
            cls_now = rjh_pkg::RJH_CLS_LOW; // [R9]
        end else if (filt_req.high) begin
            cls_now = rjh_pkg::RJH_CLS_HIGH; // [R9]
        end else begin
            cls_now = rjh_pkg::RJH_CLS_NONE;
        end
    end

    // Permit conditions from the rest of the controller
    assign cond_ok = !(pendant_active_i || tool_busy_i || running_i
                       || error_i); // [R8]
    assign axis_onehot = (filt_req.axis != 4'h0)
        && ((filt_req.axis & (filt_req.axis - 4'h1)) == 4'h0); // [R10]
    assign axis_rise = |(filt_req.axis & ~axis_prev); // [R16]
    // Start only on a fresh single request while permit shows on
    assign start_ok = permit_q && axis_rise && axis_onehot // [R7] [R10]
        && (cls_now != rjh_pkg::RJH_CLS_NONE); // [R21]
    // Request drop, link loss or a fault ends the jog
    assign stop_req = ((filt_req.axis & axis_cap) == 4'h0) // [R18]
        || !link_ok_i || error_i; // [R11]

    // Soft limits only bind once the axis position is known
    always_comb begin
        at_limit = 1'b0;
        if (homed_i) begin
            if (dir_cap) begin
                at_limit = (position_i <= lim_min); // [R12]
            end else begin
                at_limit = (position_i >= lim_max); // [R12]
            end
        end
        // Unhomed: limits not applied [R13]
    end

    // Next-state logic
    always_comb begin
        next_state = state;
        case (state)
            rjh_pkg::RJH_ST_IDLE: begin
                if (start_ok) begin
                    next_state = rjh_pkg::RJH_ST_RUN; // [R17]
                end
            end
            rjh_pkg::RJH_ST_RUN: begin
                if (stop_req) begin
                    next_state = rjh_pkg::RJH_ST_STOP; // [R18] [R11]
                end
            end
            rjh_pkg::RJH_ST_STOP: begin
                next_state = rjh_pkg::RJH_ST_IDLE; // [R18]
            end
            default: begin
                next_state = rjh_pkg::RJH_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= rjh_pkg::RJH_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Edge memory for request bits
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            axis_prev <= 4'h0;
        end else begin
            axis_prev <= filt_req.axis;
        end
    end

    // Capture conditions only at acceptance; frozen during motion
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cls_cap <= rjh_pkg::RJH_CLS_NONE;
            dir_cap <= 1'b0;
            axis_cap <= 4'h0;
        end else if (state == rjh_pkg::RJH_ST_IDLE && start_ok) begin
            cls_cap <= cls_now; // [R16] [R19]
            dir_cap <= filt_req.dir; // [R3] [R16]
            axis_cap <= filt_req.axis; // [R1]
        end
    end

    // Permit: conditions met and no jog in progress
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            permit_q <= 1'b0;
        end else begin
            permit_q <= cond_ok
                && (next_state == rjh_pkg::RJH_ST_IDLE); // [R8] [R17] [R18]
        end
    end

    // Status bytes, same on fieldbus and local connector
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            remote_sts_o <= '0;
            local_sts_o <= '0;
        end else begin
            remote_sts_o.unused <= 3'h0; // [R4]
            remote_sts_o.permit <= cond_ok
                && (next_state == rjh_pkg::RJH_ST_IDLE); // [R4]
            remote_sts_o.jogging <= (next_state == rjh_pkg::RJH_ST_RUN)
                ? ((state == rjh_pkg::RJH_ST_RUN) ? axis_cap : filt_req.axis)
                : 4'h0; // [R4] [R17]
            local_sts_o.unused <= 3'h0;
            local_sts_o.permit <= cond_ok
                && (next_state == rjh_pkg::RJH_ST_IDLE); // [R15]
            local_sts_o.jogging <= (next_state == rjh_pkg::RJH_ST_RUN)
                ? ((state == rjh_pkg::RJH_ST_RUN) ? axis_cap : filt_req.axis)
                : 4'h0; // [R15]
        end
    end

    // Motion command; run drops at a soft limit but the jog stays held
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mot_cmd_o <= '0;
        end else begin
            mot_cmd_o.run <= (state == rjh_pkg::RJH_ST_RUN) && !stop_req
                && !at_limit; // [R17] [R12] [R11]
            mot_cmd_o.axis <= axis_cap; // [R10]
            mot_cmd_o.minus <= dir_cap; // [R3]
            mot_cmd_o.inch <= (cls_cap == rjh_pkg::RJH_CLS_INCH); // [R14]
            mot_cmd_o.speed <= (cls_cap == rjh_pkg::RJH_CLS_HIGH)
                ? high_speed : low_speed; // [R14] [R2]
            mot_cmd_o.step <= inch_step; // [R14]
        end
    end

    // APB writes land at the access edge with pready high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_speed <= rjh_pkg::RST_LOW_SPEED;
            high_speed <= rjh_pkg::RST_HIGH_SPEED;
            inch_step <= rjh_pkg::RST_INCH_STEP;
            lim_min <= rjh_pkg::RST_LIM_MIN;
            lim_max <= rjh_pkg::RST_LIM_MAX;
        end else if (psel_i && penable_i && pready_o && pwrite_i) begin
            case (paddr_i)
                rjh_pkg::REG_LOW_SPEED: low_speed <= pwdata_i[15:0];
                rjh_pkg::REG_HIGH_SPEED: high_speed <= pwdata_i[15:0];
                rjh_pkg::REG_INCH_STEP: inch_step <= pwdata_i;
                rjh_pkg::REG_LIM_MIN: lim_min <= pwdata_i;
                rjh_pkg::REG_LIM_MAX: lim_max <= pwdata_i;
                default: begin
                    // Status and holes: write ignored
                end
            endcase
        end
    end

    // APB answer prepared in setup, shown in the access cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            pready_o <= 1'b1;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            case (paddr_i)
                rjh_pkg::REG_LOW_SPEED: prdata_o <= {16'h0000, low_speed};
                rjh_pkg::REG_HIGH_SPEED: prdata_o <= {16'h0000, high_speed};
                rjh_pkg::REG_INCH_STEP: prdata_o <= inch_step;
                rjh_pkg::REG_LIM_MIN: prdata_o <= lim_min;
                rjh_pkg::REG_LIM_MAX: prdata_o <= lim_max;
                rjh_pkg::REG_STATUS: begin
                    prdata_o <= {12'h000, state, cls_cap, dir_cap,
                                 permit_q, axis_cap, filt_req, 2'b00};
                end
                default: begin
                    pslverr_o <= 1'b1; // Unmapped address
                end
            endcase
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end
endmodule : rjh_jog_ctrl

/* File: logic/rjh_pkg.sv */
// Notes on behaviour
// [R1] Request bits +72..+75 select axes 0..3
// [R2] Class bits +76..+78 plus direction start motion
// [R3] Direction bit +79: off plus, on minus
// [R4] Outputs: jogging +72..+75, permit +76, rest zero
// [R5] Inputs filtered; pulses under 10 ms ignored
// [R6] Master holds each input over 30 ms
// [R7] No jog start while permit is off
// [R8] Permit off: pendant, tool, running, error
// [R9] Priority: inching, then low, then high
// [R10] Only one axis jogs at a time
// [R11] Link loss stops the jogging axis
// [R12] Homed axis confined to soft limits
// [R13] Unhomed axis jogs without soft limits
// [R14] Speeds, inch step from config; inch uses low
// [R15] Remote ORed with local; status on both
// [R16] Class and direction captured at request rise
// [R17] Accept: permit off, jogging on, then move
// [R18] Request off: stop, jogging off, permit on
// [R19] Condition changes ignored while moving
// [R20] Master checks permit, waits 30 ms between requests
// [R21] Request without class is ignored
package rjh_pkg;
    // Clock and filter timing
    localparam int CLK_HZ = 100_000_000;
    localparam int FILTER_TIME_MS = 10;
    localparam int FILTER_CYCLES = CLK_HZ / 1000 * FILTER_TIME_MS;
    localparam int FILT_CNT_W = 20;

    // Bit offsets of the jog group from the start device
    localparam int JOG_BASE_OFS = 72;
    localparam int JOG_AXIS_OFS = 72;
    localparam int JOG_INCH_OFS = 76;
    localparam int JOG_LOW_OFS = 77;
    localparam int JOG_HIGH_OFS = 78;
    localparam int JOG_DIR_OFS = 79;
    localparam int JOG_PERMIT_OFS = 76;
    localparam int NUM_AXES = 4;

    // APB register byte offsets
    localparam logic [7:0] REG_LOW_SPEED = 8'h00;
    localparam logic [7:0] REG_HIGH_SPEED = 8'h04;
    localparam logic [7:0] REG_INCH_STEP = 8'h08;
    localparam logic [7:0] REG_LIM_MIN = 8'h0c;
    localparam logic [7:0] REG_LIM_MAX = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    // Register reset values
    localparam logic [15:0] RST_LOW_SPEED = 16'h0010;
    localparam logic [15:0] RST_HIGH_SPEED = 16'h0100;
    localparam logic [31:0] RST_INCH_STEP = 32'h0000_0001;
    localparam logic [31:0] RST_LIM_MIN = 32'h8000_0000;
    localparam logic [31:0] RST_LIM_MAX = 32'h7fff_ffff;

    // Jog input byte, bit 0 is offset +72
    typedef struct packed {
        logic dir;
        logic high;
        logic low;
        logic inch;
        logic [3:0] axis;
    } rjh_jog_req_s;

    // Jog output byte, bit 0 is offset +72
    typedef struct packed {
        logic [2:0] unused;
        logic permit;
        logic [3:0] jogging;
    } rjh_jog_sts_s;

    // Speed classes after priority
    typedef enum logic [1:0] {
        RJH_CLS_NONE = 2'b00,
        RJH_CLS_INCH = 2'b01,
        RJH_CLS_LOW = 2'b10,
        RJH_CLS_HIGH = 2'b11
    } rjh_cls_e;

    // Command to the motion core
    typedef struct packed {
        logic run;
        logic [3:0] axis;
        logic minus;
        logic inch;
        logic [15:0] speed;
        logic [31:0] step;
    } rjh_mot_cmd_s;

    // Handshake states, Gray along idle-run-stop
    typedef enum logic [1:0] {
        RJH_ST_IDLE = 2'b00,
        RJH_ST_RUN = 2'b01,
        RJH_ST_STOP = 2'b11
    } rjh_state_e;
endpackage : rjh_pkg

/* File: verification/rjh_master_model.sv */
`timescale 1ns/10ps
// Master station: conditions first, then the request bits, long holds
module rjh_master_model #(
    parameter int HOLD = 26
) (
    input wire logic clk_i,
    output rjh_pkg::rjh_jog_req_s req_o
);
    // Idle master keeps every bit off
    initial req_o = '0;
    // Set class and direction, then let them settle
    task automatic cond(input logic [2:0] cl, input logic dr);
        @(posedge clk_i);
        req_o[7:4] <= {dr, cl};
        repeat (HOLD) @(posedge clk_i);
    endtask : cond
    // Raise the request only after conditions stood a full hold
    task automatic start(input logic [3:0] ax, input logic [2:0] cl,
                         input logic dr);
        cond(cl, dr);
        @(posedge clk_i);
        req_o.axis <= ax;
        repeat (HOLD) @(posedge clk_i);
    endtask : start
    // Drop the request, then keep quiet a full hold
    task automatic stop();
        @(posedge clk_i);
        req_o.axis <= 4'h0;
        repeat (HOLD) @(posedge clk_i);
    endtask : stop
    // Too short on purpose, only for the filter scenario
    task automatic pulse(input logic [3:0] ax, input int n);
        @(posedge clk_i);
        req_o.axis <= ax;
        repeat (n) @(posedge clk_i);
        req_o.axis <= 4'h0;
        repeat (HOLD) @(posedge clk_i);
    endtask : pulse
endmodule : rjh_master_model

/* File: verification/rjh_jog_ctrl_sva.sv */
`timescale 1ns/10ps
// Port-level checks of the jog handshake
module rjh_jog_ctrl_sva (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic link_ok_i,
    input wire logic pendant_active_i,
    input wire logic tool_busy_i,
    input wire logic running_i,
    input wire logic error_i,
    input wire logic homed_i,
    input wire rjh_pkg::rjh_jog_req_s local_req_i,
    input wire rjh_pkg::rjh_jog_sts_s remote_sts_o,
    input wire rjh_pkg::rjh_jog_sts_s local_sts_o,
    input wire rjh_pkg::rjh_mot_cmd_s mot_cmd_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // First cycle of a jog
    sequence s_jog_rise;
        $rose(|remote_sts_o.jogging);
    endsequence
    // Any condition that forbids jogging
    sequence s_blocked;
        pendant_active_i || tool_busy_i || running_i || error_i;
    endsequence
    a_sts_mirror: assert property (local_sts_o == remote_sts_o)
        else $error("local status differs from remote status");
    a_unused_zero: assert property (remote_sts_o.unused == 3'b000)
        else $error("unused status bits not zero");
    a_one_axis: assert property ($onehot0(remote_sts_o.jogging))
        else $error("more than one axis jogging");
    a_permit_block: assert property
        (s_blocked |=> !remote_sts_o.permit)
        else $error("permit on while blocked");
    a_permit_excl: assert property
        (|remote_sts_o.jogging |-> !remote_sts_o.permit)
        else $error("permit on while jogging");
    a_start_permit: assert property
        (s_jog_rise |-> $past(remote_sts_o.permit))
        else $error("jog started without permit");
    a_start_run: assert property
        (s_jog_rise ##1 !homed_i |-> mot_cmd_o.run)
        else $error("motion did not follow jog start");
    a_run_axis: assert property
        (mot_cmd_o.run |-> remote_sts_o.jogging == mot_cmd_o.axis)
        else $error("motion axis differs from jogging axis");
    a_cond_hold: assert property
        (mot_cmd_o.run && $past(mot_cmd_o.run) |->
        $stable(mot_cmd_o.minus) && $stable(mot_cmd_o.inch))
        else $error("conditions changed during motion");
    a_link_stop: assert property ($fell(link_ok_i) &&
        |remote_sts_o.jogging && local_req_i.axis == 4'h0 |->
        ##[1:2] remote_sts_o.jogging == 4'h0)
        else $error("jog kept running after link loss");
    a_pready_next: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready in access cycle");
endmodule : rjh_jog_ctrl_sva
bind rjh_jog_ctrl rjh_jog_ctrl_sva rjh_jog_ctrl_sva_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pready_o(pready_o), .link_ok_i(link_ok_i), .error_i(error_i),
    .pendant_active_i(pendant_active_i), .tool_busy_i(tool_busy_i),
    .running_i(running_i), .homed_i(homed_i), .local_req_i(local_req_i),
    .remote_sts_o(remote_sts_o), .local_sts_o(local_sts_o),
    .mot_cmd_o(mot_cmd_o));

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    localparam int FC = 8; // Short filter keeps the run brief
    localparam int HOLD = 3 * FC + 2; // Hold two cycles over three filter times
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o;
    logic link_ok_i = 1'b1;
    logic homed_i = 1'b0;
    logic [3:0] blk = 4'h0; // Pendant, tool, running, error
    rjh_pkg::rjh_jog_req_s remote_req_i, local_req_i;
    rjh_pkg::rjh_jog_sts_s remote_sts_o, local_sts_o;
    rjh_pkg::rjh_mot_cmd_s mot_cmd_o;
    int err_total = 0;
    int checked = 0;
    int jog_cyc = 0; // Cycles with any axis jogging, never cleared
    logic [15:0] lo, hi; // Speeds written at start
    logic [31:0] seed = 32'he684f9ae;
    logic [31:0] rst_tab [5] = '{32'(rjh_pkg::RST_LOW_SPEED),
        32'(rjh_pkg::RST_HIGH_SPEED), rjh_pkg::RST_INCH_STEP,
        rjh_pkg::RST_LIM_MIN, rjh_pkg::RST_LIM_MAX};
    always #5 clk_i = ~clk_i;
    // Catch jogs that rise and fall between checks; one writer only
    always @(posedge clk_i) begin
        if (|remote_sts_o.jogging) begin
            jog_cyc <= jog_cyc + 1;
        end
    end
    rjh_jog_ctrl #(.FILTER_CYCLES(FC)) rjh_jog_ctrl_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .link_ok_i(link_ok_i), .remote_req_i(remote_req_i),
        .remote_sts_o(remote_sts_o), .local_req_i(local_req_i),
        .local_sts_o(local_sts_o), .pendant_active_i(blk[0]),
        .tool_busy_i(blk[1]), .running_i(blk[2]), .error_i(blk[3]),
        .homed_i(homed_i), .position_i(32'sh200), .mot_cmd_o(mot_cmd_o));
    // Fieldbus master and local connector
    rjh_master_model #(.HOLD(HOLD)) rem_m (.clk_i(clk_i),
        .req_o(remote_req_i));
    rjh_master_model #(.HOLD(HOLD)) loc_m (.clk_i(clk_i), .req_o(local_req_i));
    // Xorshift, fixed seed
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [32:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            tally_and_finish();
        end
        q = {pslverr_o, prdata_o};
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // Master looks at permit before each request
    task automatic wait_permit();
        int n;
        for (n = 0; remote_sts_o.permit !== 1'b1; n++) begin
            if (n > 200) begin
                err_total++;
                tally_and_finish();
            end
            @(posedge clk_i);
        end
    endtask : wait_permit
    // Full jog: start, change conditions, stop, clear conditions
    task automatic jog(input logic [3:0] ax, input logic [2:0] cl,
                       input logic dr, input logic loc);
        logic [22:0] exp;
        wait_permit();
        if (loc) loc_m.start(ax, cl, dr);
        else rem_m.start(ax, cl, dr);
        // Built after the start so a fresh homed level is seen
        // Only a lone high-speed request runs at high speed
        exp = {!(homed_i && !dr), ax, dr, cl[0], cl == 3'b100 ? hi : lo};
        check({local_sts_o, remote_sts_o},
              {2{4'h0, ax}});
        check(mot_cmd_o[54:32], exp);
        check(mot_cmd_o.step, rjh_pkg::RST_INCH_STEP);
        if (loc) loc_m.cond(~cl, ~dr);
        else rem_m.cond(~cl, ~dr);
        check(mot_cmd_o[54:32], exp);
        if (loc) loc_m.stop();
        else rem_m.stop();
        check({mot_cmd_o.run, remote_sts_o}, 9'h010);
        // Leftover conditions would OR into the other source's jog
        if (loc) loc_m.cond(3'b000, 1'b0);
        else rem_m.cond(3'b000, 1'b0);
    endtask : jog
    // Request that must not start a jog: no jogging cycle may be added
    task automatic refuse(input logic [3:0] ax, input logic [2:0] cl);
        int c0;
        c0 = jog_cyc;
        rem_m.start(ax, cl, 1'b0);
        check({jog_cyc == c0, remote_sts_o.permit},
              {1'b1, blk == 4'h0});
        rem_m.stop();
    endtask : refuse
    initial begin
        int i;
        logic [32:0] q;
        logic [31:0] r;
        int c0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0, q);
            check(q, {1'b0, rst_tab[i]});
        end
        apb(1'b1, 8'h18, 32'h1234, q);
        check(q, 33'h1_0000_0000); // Unmapped word
        r = rnd();
        lo = r[15:0];
        hi = r[31:16];
        apb(1'b1, rjh_pkg::REG_LOW_SPEED, {16'h0, lo}, q);
        apb(1'b1, rjh_pkg::REG_HIGH_SPEED, {16'h0, hi}, q);
        apb(1'b1, rjh_pkg::REG_LIM_MAX, 32'h100, q); // Below the position
        apb(1'b0, rjh_pkg::REG_HIGH_SPEED, 32'h0, q);
        check(q[15:0], hi);
        // Random jogs, all classes together first, one from local
        for (i = 0; i < 8; i++) begin
            r = rnd();
            if (r[2:0] == 3'b000 || i == 0) r[2:0] = 3'b111;
            homed_i <= r[4];
            jog(4'h1 << (i % 4), r[2:0], r[3], i == 5);
        end
        homed_i <= 1'b0;
        refuse(4'h2, 3'b000);
        refuse(4'h3, 3'b010);
        rem_m.cond(3'b010, 1'b0);
        c0 = jog_cyc;
        rem_m.pulse(4'h1, FC - 3);
        check(jog_cyc - c0, 0);
        // Each blocking condition in turn; the next one replaces it
        for (i = 0; i < 4; i++) begin
            blk <= 4'h1 << i;
            refuse(4'h1, 3'b010);
        end
        blk <= 4'h0;
        wait_permit();
        rem_m.start(4'h4, 3'b010, 1'b0);
        check(remote_sts_o.jogging, 4'h4);
        link_ok_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check({mot_cmd_o.run, remote_sts_o.jogging}, 5'h00);
        rem_m.stop();
        link_ok_i <= 1'b1;
        tally_and_finish();
    end
endmodule : tb_top
